// ===== include/ais_params.svh
// offsets, field positions and reset values of the input and reference select block
// assumes an 8-bit register port with byte addresses as printed
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH

`define AIS_OFS_RESULT_LOW 8'h78
`define AIS_OFS_RESULT_HIGH 8'h79
`define AIS_OFS_CONTROL_A 8'h7A
`define AIS_OFS_CONTROL_B 8'h7B
`define AIS_OFS_INPUT_REF 8'h7C
`define AIS_OFS_STATUS 8'h7D

`define AIS_BIT_REF_HI 7
`define AIS_BIT_REF_LO 6
`define AIS_BIT_LEFT_ALIGN 5
`define AIS_BIT_CHAN_LOW_HI 4
`define AIS_BIT_CHAN_LOW_LO 0
`define AIS_BIT_CMP_MUX_EN 6
`define AIS_BIT_CHAN_HIGH 3
`define AIS_BIT_TRIG_HI 2
`define AIS_BIT_TRIG_LO 0
`define AIS_BIT_BUSY 6
`define AIS_BIT_DONE_FLAG 4
`define AIS_BIT_ST_BUSY 0
`define AIS_BIT_ST_REF_WARN 1
`define AIS_BIT_ST_RESERVED 2
`define AIS_BIT_ST_PENDING 3

`define AIS_RST_INPUT_REF 8'h00
`define AIS_RST_CONTROL_B 8'h00
`define AIS_RST_RESULT 10'h000
`define AIS_READ_UNMAPPED 8'h00

`endif

// ===== include/ais_pkg.sv
// types shared by the input and reference select block
// no dependencies
package ais_pkg;

	typedef enum logic [1:0] {
		AIS_REF_EXTERNAL,
		AIS_REF_SUPPLY,
		AIS_REF_1V1,
		AIS_REF_2V56
	} ais_ref_t;

	typedef enum logic [2:0] {
		AIS_IN_NONE,
		AIS_IN_SINGLE,
		AIS_IN_DIFF,
		AIS_IN_BANDGAP,
		AIS_IN_GROUND
	} ais_kind_t;

	typedef enum logic [1:0] {
		AIS_GAIN_1X,
		AIS_GAIN_10X,
		AIS_GAIN_200X
	} ais_gain_t;

	typedef struct packed {
		ais_kind_t kind;
		logic [3:0] pos;
		logic [3:0] neg;
		ais_gain_t gain;
	} ais_route_t;

	typedef enum logic {
		AIS_ST_IDLE,
		AIS_ST_CONVERT
	} ais_state_t;

endpackage

// ===== rtl/ais_channel_decode.sv
// decodes a 6-bit channel and gain code into a multiplexer route
// purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none

module ais_channel_decode (
	// code in
	input wire logic [5:0] code_i,
	// route out
	output ais_pkg::ais_route_t route_o
);

	always_comb begin
		route_o.kind = ais_pkg::AIS_IN_NONE;
		route_o.pos = 4'h0;
		route_o.neg = 4'h0;
		route_o.gain = ais_pkg::AIS_GAIN_1X;
		unique case (code_i[4:3])
			2'b00: begin
				route_o.kind = ais_pkg::AIS_IN_SINGLE;
				route_o.pos = {code_i[5], code_i[2:0]};
			end
			2'b01: begin
				route_o.kind = ais_pkg::AIS_IN_DIFF;
				route_o.gain = code_i[1] ? ais_pkg::AIS_GAIN_200X : ais_pkg::AIS_GAIN_10X;
				route_o.neg = {code_i[5], 1'b0, code_i[2], 1'b0};
				route_o.pos = {code_i[5], 1'b0, code_i[2], code_i[0]};
			end
			2'b10, 2'b11: begin
				if (code_i[3:0] == 4'hE) begin
					// high half of these codes is reserved
					route_o.kind = code_i[5] ? ais_pkg::AIS_IN_NONE : ais_pkg::AIS_IN_BANDGAP;
				end else if (code_i[3:0] == 4'hF) begin
					route_o.kind = code_i[5] ? ais_pkg::AIS_IN_NONE : ais_pkg::AIS_IN_GROUND;
				end else begin
					route_o.kind = ais_pkg::AIS_IN_DIFF;
					route_o.pos = {code_i[5], code_i[2:0]};
					route_o.neg = code_i[3] ? {code_i[5], 3'h2} : {code_i[5], 3'h1};
				end
			end
		endcase
	end

endmodule

`default_nettype wire

// ===== rtl/ais_result_align.sv
// places a 10-bit conversion result into two readable bytes
// combinational; alignment bit comes straight from the live register
`timescale 1ns/1ps
`default_nettype none

module ais_result_align (
	// result and alignment
	input wire logic [9:0] result_i,
	input wire logic left_align_i,
	// bytes
	output logic [7:0] high_o,
	output logic [7:0] low_o
);

	always_comb begin
		if (left_align_i) begin
			high_o = result_i[9:2];
			low_o = {result_i[1:0], 6'h00};
		end else begin
			high_o = {6'h00, result_i[9:8]};
			low_o = result_i[7:0];
		end
	end

endmodule

`default_nettype wire

// ===== rtl/ais_top.sv
// converter input, gain and reference selection with result presentation
// and a status flag for selection writes held off by an already running conversion
// assumes a sequencer on clock_i that pulses start and done, and a plain
// 8-bit register port whose read data appear one cycle after the strobe
//
// Operation
// - two-bit field picks converter reference source
// - reference change waits for running conversion
// - alignment bit changes readable result immediately
// - channel code is five low plus one high
// - low channel change waits for conversion end
// - low codes select single-ended inputs 0-15
// - gain and unity differential pair codes
// - codes route bandgap or ground single-ended
// - second control register field layout, rest zero
// - high channel change waits for conversion end
// - eight-input variant ignores high channel bit
// - done flag set when result updated
// - left or right result byte placement
`include "ais_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ais_top #(
	parameter bit HAS_HIGH_INPUTS = 1'b1
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	// conversion sequencer
	input wire logic conv_start_i,
	input wire logic conv_done_i,
	input wire logic [9:0] conv_result_i,
	// analog front end controls
	output ais_pkg::ais_ref_t reference_select_o,
	output logic internal_ref_enable_o,
	output ais_pkg::ais_route_t route_o,
	output logic [5:0] channel_gain_code_o,
	output logic comparator_mux_enable_o,
	output logic [2:0] trigger_source_select_o,
	// status
	output logic busy_o,
	output logic conversion_done_flag_o
);

	// software-visible registers
	logic [1:0] reference_select_q;
	logic result_left_align_q;
	logic [4:0] channel_select_low_q;
	logic channel_select_high_q;
	logic comparator_mux_enable_q;
	logic [2:0] trigger_source_select_q;
	logic conversion_done_flag_q;
	logic [9:0] result_q;
	logic [7:0] rdata_q;

	// conversion tracking and working copy
	ais_pkg::ais_state_t state_q;
	logic [1:0] active_ref_q;
	logic [5:0] active_code_q;
	ais_pkg::ais_ref_t ref_out_q;
	logic int_ref_on_q;
	ais_pkg::ais_route_t route_q;
	logic ref_warn_q;
	logic reserved_q;
	// run and held-off-write flags, kept as flops so no pin is a decode
	logic busy_q;
	logic pending_q;

	// decode helpers
	logic wr_input_ref;
	logic wr_control_b;
	logic wr_control_a;
	logic start_taken;
	logic done_taken;
	logic load_working;
	logic sel_written;
	logic route_diff;
	logic route_gained;
	logic ref_misuse;
	logic [5:0] reg_code;
	logic [5:0] next_code;
	logic [1:0] next_ref;
	ais_pkg::ais_route_t next_route;
	logic [7:0] res_high;
	logic [7:0] res_low;
	logic [7:0] control_a_rd;
	logic [7:0] control_b_rd;
	logic [7:0] input_ref_rd;
	logic [7:0] status_rd;
	logic [7:0] rdata_d;

	assign wr_input_ref = reg_write_i && (reg_addr_i == `AIS_OFS_INPUT_REF);
	assign wr_control_b = reg_write_i && (reg_addr_i == `AIS_OFS_CONTROL_B);
	assign wr_control_a = reg_write_i && (reg_addr_i == `AIS_OFS_CONTROL_A);
	assign sel_written = wr_input_ref || wr_control_b;

	// a start during a running conversion is ignored by this block
	assign start_taken = conv_start_i && (state_q == ais_pkg::AIS_ST_IDLE);
	assign done_taken = conv_done_i && (state_q == ais_pkg::AIS_ST_CONVERT);

	// high bit means nothing on the eight-input variant
	assign reg_code = {channel_select_high_q & HAS_HIGH_INPUTS, channel_select_low_q};

	// idle loads every cycle, so the start edge captures the live registers
	// working copy follows registers except while a conversion runs
	assign load_working = (state_q == ais_pkg::AIS_ST_IDLE) || done_taken;

	always_comb begin
		if (load_working) begin
			next_code = reg_code;
			next_ref = reference_select_q;
		end else begin
			next_code = active_code_q;
			next_ref = active_ref_q;
		end
	end

	ais_channel_decode u_decode (
		.code_i(next_code),
		.route_o(next_route)
	);

	ais_result_align u_align (
		.result_i(result_q),
		.left_align_i(result_left_align_q),
		.high_o(res_high),
		.low_o(res_low)
	);

	// conversion state
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_q <= ais_pkg::AIS_ST_IDLE;
		end else begin
			unique case (state_q)
				ais_pkg::AIS_ST_IDLE: begin
					if (start_taken) begin
						state_q <= ais_pkg::AIS_ST_CONVERT;
					end
				end
				ais_pkg::AIS_ST_CONVERT: begin
					if (done_taken) begin
						state_q <= ais_pkg::AIS_ST_IDLE;
					end
				end
			endcase
		end
	end

	// busy follows the same edges as the state
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			busy_q <= 1'b0;
		end else if (start_taken) begin
			busy_q <= 1'b1;
		end else if (done_taken) begin
			busy_q <= 1'b0;
		end
	end

	// a selection write held off by a running conversion;
	// it clears on the done edge, where the held value is taken
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pending_q <= 1'b0;
		end else if (done_taken) begin
			pending_q <= 1'b0;
		end else if (busy_q && sel_written) begin
			pending_q <= 1'b1;
		end
	end

	// input and reference select register
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reference_select_q <= 2'(`AIS_RST_INPUT_REF >> `AIS_BIT_REF_LO);
			result_left_align_q <= 1'b0;
			channel_select_low_q <= 5'h00;
		end else if (wr_input_ref) begin
			reference_select_q <= reg_wdata_i[`AIS_BIT_REF_HI:`AIS_BIT_REF_LO];
			result_left_align_q <= reg_wdata_i[`AIS_BIT_LEFT_ALIGN];
			channel_select_low_q <= reg_wdata_i[`AIS_BIT_CHAN_LOW_HI:`AIS_BIT_CHAN_LOW_LO];
		end
	end

	// second control register; unlisted bits are not stored
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			comparator_mux_enable_q <= 1'b0;
			channel_select_high_q <= 1'b0;
			trigger_source_select_q <= 3'h0;
		end else if (wr_control_b) begin
			comparator_mux_enable_q <= reg_wdata_i[`AIS_BIT_CMP_MUX_EN];
			channel_select_high_q <= reg_wdata_i[`AIS_BIT_CHAN_HIGH];
			trigger_source_select_q <= reg_wdata_i[`AIS_BIT_TRIG_HI:`AIS_BIT_TRIG_LO];
		end
	end

	// result is captured in the same cycle that raises the done flag
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			result_q <= `AIS_RST_RESULT;
		end else if (done_taken) begin
			result_q <= conv_result_i;
		end
	end

	// done flag: written one clears, a completion in the same cycle wins
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			conversion_done_flag_q <= 1'b0;
		end else if (done_taken) begin
			conversion_done_flag_q <= 1'b1;
		end else if (wr_control_a && reg_wdata_i[`AIS_BIT_DONE_FLAG]) begin
			conversion_done_flag_q <= 1'b0;
		end
	end

	// working copy of reference and channel code
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			active_ref_q <= 2'h0;
			active_code_q <= 6'h00;
		end else begin
			active_ref_q <= next_ref;
			active_code_q <= next_code;
		end
	end

	// analog controls registered from the working copy
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ref_out_q <= ais_pkg::AIS_REF_EXTERNAL;
			int_ref_on_q <= 1'b0;
		end else begin
			ref_out_q <= ais_pkg::ais_ref_t'(next_ref);
			int_ref_on_q <= next_ref[1];
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			route_q <= '{kind: ais_pkg::AIS_IN_SINGLE, pos: 4'h0, neg: 4'h0,
				gain: ais_pkg::AIS_GAIN_1X};
		end else begin
			route_q <= next_route;
		end
	end

	// software is meant to avoid these mixes; the flag only reports them
	assign route_diff = (next_route.kind == ais_pkg::AIS_IN_DIFF);
	assign route_gained = (next_route.gain != ais_pkg::AIS_GAIN_1X);
	assign ref_misuse = route_diff
		&& ((next_ref == 2'h2) || (route_gained && (next_ref != 2'h3)));

	// misuse indications: bad reference for the chosen gain, or reserved code
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ref_warn_q <= 1'b0;
			reserved_q <= 1'b0;
		end else begin
			ref_warn_q <= ref_misuse;
			reserved_q <= (next_route.kind == ais_pkg::AIS_IN_NONE);
		end
	end

	// readback images
	always_comb begin
		input_ref_rd = 8'h00;
		input_ref_rd[`AIS_BIT_REF_HI:`AIS_BIT_REF_LO] = reference_select_q;
		input_ref_rd[`AIS_BIT_LEFT_ALIGN] = result_left_align_q;
		input_ref_rd[`AIS_BIT_CHAN_LOW_HI:`AIS_BIT_CHAN_LOW_LO] = channel_select_low_q;
	end

	always_comb begin
		control_b_rd = 8'h00;
		control_b_rd[`AIS_BIT_CMP_MUX_EN] = comparator_mux_enable_q;
		control_b_rd[`AIS_BIT_CHAN_HIGH] = channel_select_high_q;
		control_b_rd[`AIS_BIT_TRIG_HI:`AIS_BIT_TRIG_LO] = trigger_source_select_q;
	end

	always_comb begin
		control_a_rd = 8'h00;
		control_a_rd[`AIS_BIT_BUSY] = busy_q;
		control_a_rd[`AIS_BIT_DONE_FLAG] = conversion_done_flag_q;
	end

	always_comb begin
		status_rd = 8'h00;
		status_rd[`AIS_BIT_ST_BUSY] = busy_q;
		status_rd[`AIS_BIT_ST_REF_WARN] = ref_warn_q;
		status_rd[`AIS_BIT_ST_RESERVED] = reserved_q;
		status_rd[`AIS_BIT_ST_PENDING] = pending_q;
	end

	// read mux; result bytes use the live alignment bit
	always_comb begin
		rdata_d = `AIS_READ_UNMAPPED;
		if (reg_read_i) begin
			unique case (reg_addr_i)
				`AIS_OFS_RESULT_LOW: rdata_d = res_low;
				`AIS_OFS_RESULT_HIGH: rdata_d = res_high;
				`AIS_OFS_CONTROL_A: rdata_d = control_a_rd;
				`AIS_OFS_CONTROL_B: rdata_d = control_b_rd;
				`AIS_OFS_INPUT_REF: rdata_d = input_ref_rd;
				`AIS_OFS_STATUS: rdata_d = status_rd;
				default: rdata_d = `AIS_READ_UNMAPPED;
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rdata_q <= `AIS_READ_UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// every pin below is a flop; none is decoded on the way out
	assign reg_rdata_o = rdata_q;
	assign reference_select_o = ref_out_q;
	assign internal_ref_enable_o = int_ref_on_q;
	assign route_o = route_q;
	assign channel_gain_code_o = active_code_q;
	assign comparator_mux_enable_o = comparator_mux_enable_q;
	assign trigger_source_select_o = trigger_source_select_q;
	assign busy_o = busy_q;
	assign conversion_done_flag_o = conversion_done_flag_q;

endmodule

`default_nettype wire

// ===== bench/ais_top_assertions.sv
// port-level checker for the input and reference select block
// bound to ais_top from the bench top file
`timescale 1ns/1ps
`default_nettype none

module ais_top_checker (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// requests
	input wire logic reg_read_i,
	input wire logic reg_write_i,
	input wire logic conv_start_i,
	input wire logic conv_done_i,
	// answers
	input wire logic [7:0] reg_rdata_o,
	input wire ais_pkg::ais_ref_t reference_select_o,
	input wire logic internal_ref_enable_o,
	input wire ais_pkg::ais_route_t route_o,
	input wire logic [5:0] channel_gain_code_o,
	input wire logic busy_o,
	input wire logic conversion_done_flag_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	AST_START_BUSY: assert property (!busy_o && conv_start_i |=> busy_o)
		else $error("start while idle did not raise busy");
	AST_FREEZE: assert property (busy_o && !conv_done_i |=> $stable(reference_select_o)
		&& $stable(channel_gain_code_o) && $stable(route_o))
		else $error("selection moved during a conversion");
	AST_DONE: assert property (busy_o && conv_done_i |=> !busy_o && conversion_done_flag_o)
		else $error("done did not end conversion and set flag");
	AST_STICKY: assert property (conversion_done_flag_o && !reg_write_i |=> conversion_done_flag_o)
		else $error("done flag dropped without a write");
	AST_INT_REF: assert property (internal_ref_enable_o == (reference_select_o >= ais_pkg::AIS_REF_1V1))
		else $error("internal reference enable wrong");
	AST_BANDGAP: assert property (channel_gain_code_o == 6'h1E |-> route_o.kind == ais_pkg::AIS_IN_BANDGAP)
		else $error("bandgap code not routed");
	AST_GROUND: assert property (channel_gain_code_o == 6'h1F |-> route_o.kind == ais_pkg::AIS_IN_GROUND)
		else $error("ground code not routed");
	AST_RESERVED: assert property (channel_gain_code_o[5:1] == 5'h1F |-> route_o.kind == ais_pkg::AIS_IN_NONE)
		else $error("reserved code selected an input");
	AST_SINGLE: assert property (channel_gain_code_o[4:3] == 2'h0 |-> route_o.kind == ais_pkg::AIS_IN_SINGLE
		&& route_o.pos == {channel_gain_code_o[5], channel_gain_code_o[2:0]})
		else $error("single-ended code routed wrongly");
	AST_RDATA_IDLE: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
		else $error("read data without a read");
endmodule

`default_nettype wire

// ===== bench/ais_front_model.sv
// sequencer and analog front end standing in for the far side
// bench asks with go_i; wait_i sets how long the conversion runs
`timescale 1ns/1ps
`default_nettype none

module ais_front_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// bench request
	input wire logic go_i,
	input wire logic [3:0] wait_i,
	input wire logic [9:0] value_i,
	// sequencer side of the block
	output logic conv_start_o,
	output logic conv_done_o,
	output logic [9:0] conv_result_o
);
	logic run_q;
	logic [3:0] cnt_q;

	always_ff @(posedge clock_i) begin
		conv_start_o <= 1'b0;
		conv_done_o <= 1'b0;
		// result only valid beside done, so keep it moving otherwise
		conv_result_o <= ~conv_result_o;
		if (reset_i) begin
			run_q <= 1'b0;
			cnt_q <= 4'h0;
			conv_result_o <= 10'h000;
		end else if (run_q) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h0) begin
				run_q <= 1'b0;
				conv_done_o <= 1'b1;
				conv_result_o <= value_i;
			end
		end else if (go_i) begin
			run_q <= 1'b1;
			cnt_q <= wait_i;
			conv_start_o <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// ===== bench/ais_top_tb.sv
// self-checking bench for the input and reference select block
// a front model drives the sequencer pins; a second instance lacks high inputs
`timescale 1ns/1ps
`default_nettype none

module ais_top_tb;
	typedef struct packed {
		logic [7:0] ctl_b;
		logic [7:0] sel;
		logic [2:0] kind;
		logic [3:0] pos;
		logic [3:0] neg;
		logic [1:0] gain;
	} ais_row_t;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic conv_start_i;
	logic conv_done_i;
	logic [9:0] conv_result_i;
	ais_pkg::ais_ref_t reference_select_o;
	logic internal_ref_enable_o;
	ais_pkg::ais_route_t route_o;
	logic [5:0] channel_gain_code_o;
	logic comparator_mux_enable_o;
	logic [2:0] trigger_source_select_o;
	logic busy_o;
	logic conversion_done_flag_o;
	logic go = 1'b0;
	logic [3:0] wt = 4'h0;
	logic [9:0] val = 10'h000;
	logic [5:0] code_narrow;
	int miscompares = 0;
	int samples_checked = 0;
	// kind 1 single, 2 diff, 3 bandgap, 4 ground, 0 none
	ais_row_t rows [11] = '{
		'{8'h00, 8'hC5, 3'h1, 4'h5, 4'h0, 2'h0}, '{8'h08, 8'h07, 3'h1, 4'hF, 4'h0, 2'h0},
		'{8'h08, 8'h40, 3'h1, 4'h8, 4'h0, 2'h0}, '{8'h00, 8'hCB, 3'h2, 4'h1, 4'h0, 2'h2},
		'{8'h00, 8'hCC, 3'h2, 4'h2, 4'h2, 2'h1}, '{8'h00, 8'h50, 3'h2, 4'h0, 4'h1, 2'h0},
		'{8'h00, 8'h1D, 3'h2, 4'h5, 4'h2, 2'h0}, '{8'h00, 8'h9E, 3'h3, 4'h0, 4'h0, 2'h0},
		'{8'h00, 8'h1F, 3'h4, 4'h0, 4'h0, 2'h0}, '{8'h08, 8'h1E, 3'h0, 4'h0, 4'h0, 2'h0},
		'{8'h08, 8'h10, 3'h2, 4'h8, 4'h9, 2'h0}};

	ais_top uut (.*);
	ais_top #(.HAS_HIGH_INPUTS(1'b0)) uut2 (.*, .reg_rdata_o(), .reference_select_o(),
		.internal_ref_enable_o(), .route_o(), .channel_gain_code_o(code_narrow),
		.comparator_mux_enable_o(), .trigger_source_select_o(), .busy_o(),
		.conversion_done_flag_o());
	ais_front_model partner (.clock_i(clock_i), .reset_i(reset_i), .go_i(go), .wait_i(wt),
		.value_i(val), .conv_start_o(conv_start_i), .conv_done_o(conv_done_i),
		.conv_result_o(conv_result_i));

	always #50 clock_i = ~clock_i;

	task complete_run();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clock_i);
		reg_read_i <= 1'b0;
		#1;
		check(reg_rdata_o & m, exp);
	endtask

	task wait_busy(input logic lvl);
		int n;
		n = 0;
		#1;
		while (busy_o !== lvl && n < 40) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		if (busy_o !== lvl) begin
			miscompares++;
			complete_run();
		end
	endtask

	task start(input logic [9:0] v, input logic [3:0] w);
		@(posedge clock_i);
		val <= v;
		wt <= w;
		go <= 1'b1;
		@(posedge clock_i);
		go <= 1'b0;
		wait_busy(1'b1);
	endtask

	// every pin plus the input select, control B and result high registers back at reset value
	task check_idle();
		check(busy_o, 16'h0000);
		check(conversion_done_flag_o, 16'h0000);
		check(reference_select_o, 16'h0000);
		check(internal_ref_enable_o, 16'h0000);
		check(channel_gain_code_o, 16'h0000);
		check(route_o, {3'h1, 4'h0, 4'h0, 2'h0});
		check(comparator_mux_enable_o, 16'h0000);
		check(trigger_source_select_o, 16'h0000);
		rd(8'h7C, 8'hFF, 8'h00);
		rd(8'h7B, 8'hFF, 8'h00);
		rd(8'h79, 8'hFF, 8'h00);
	endtask

	initial begin
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		tick(1);
		check_idle();
		wr(8'h7B, 8'hFF);
		rd(8'h7B, 8'hFF, 8'h4F);
		tick(2);
		check(comparator_mux_enable_o, 16'h0001);
		check(trigger_source_select_o, 16'h0007);
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'hFF, 8'h00);
		wr(8'h7C, 8'hFF);
		rd(8'h7C, 8'hFF, 8'hFF);
		foreach (rows[i]) begin
			wr(8'h7B, rows[i].ctl_b);
			wr(8'h7C, rows[i].sel);
			tick(2);
			check(reference_select_o, rows[i].sel[7:6]);
			check(internal_ref_enable_o, rows[i].sel[7]);
			check(channel_gain_code_o, {rows[i].ctl_b[3], rows[i].sel[4:0]});
			check(code_narrow, {1'b0, rows[i].sel[4:0]});
			check(route_o.kind, rows[i].kind);
			if (rows[i].kind inside {3'h1, 3'h2}) begin
				check(route_o.pos, rows[i].pos);
			end
			if (rows[i].kind == 3'h2) begin
				check(route_o.neg, rows[i].neg);
				check(route_o.gain, rows[i].gain);
			end
			rd(8'h7D, 8'h07, {5'h00, rows[i].kind == 3'h0, 2'b00});
		end
		// writes while busy must wait for the done edge
		wr(8'h7B, 8'h00);
		wr(8'h7C, 8'h41);
		start(10'h270, 4'hC);
		wr(8'h7C, 8'hC2);
		wr(8'h7B, 8'h08);
		tick(1);
		check(reference_select_o, 16'h0001);
		check(channel_gain_code_o, 16'h0001);
		check(busy_o, 16'h0001);
		check(internal_ref_enable_o, 16'h0000);
		rd(8'h7D, 8'h0F, 8'h09);
		rd(8'h7A, 8'h50, 8'h40);
		wait_busy(1'b0);
		check(reference_select_o, 16'h0003);
		check(channel_gain_code_o, 16'h0022);
		check(conversion_done_flag_o, 16'h0001);
		check(internal_ref_enable_o, 16'h0001);
		rd(8'h7D, 8'h0F, 8'h00);
		rd(8'h7A, 8'h50, 8'h10);
		rd(8'h78, 8'hFF, 8'h70);
		rd(8'h79, 8'hFF, 8'h02);
		// alignment acts at once, even mid-conversion
		start(10'h3FF, 4'hC);
		wr(8'h7C, 8'hE2);
		rd(8'h79, 8'hFF, 8'h9C);
		rd(8'h78, 8'hFF, 8'h00);
		wait_busy(1'b0);
		rd(8'h79, 8'hFF, 8'hFF);
		rd(8'h78, 8'hFF, 8'hC0);
		wr(8'h7A, 8'h10);
		rd(8'h7A, 8'h50, 8'h00);
		check(conversion_done_flag_o, 16'h0000);
		// reset in mid-conversion drops the run and every register
		start(10'h155, 4'hC);
		wr(8'h7B, 8'h4F);
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		tick(1);
		check_idle();
		complete_run();
	end
endmodule

bind ais_top ais_top_checker chk (.*);

`default_nettype wire
